//--- verilog/cht_pkg.sv
/*
 * constants and state types shared by the capacitive hysteresis tracker.
 * assumes a 40 MHz system clock; no bus, all settings arrive as plain ports.
 */
package cht_pkg;
	localparam int NUM_CH = 3;
	localparam int CNT_W = 12;
	localparam int HALT_W = 8;
	localparam int TIMER_W = 24;
	localparam int TICK_W = 8;
	localparam int CLK_FREQ_MHZ = 40;
	localparam int T_CHANNEL_US = 9000;
	localparam int T_XFER_NS = 1000;
	localparam int T_DISCHARGE_NS = 1000;
	localparam int CHANNEL_CYCLES_DFLT = T_CHANNEL_US * CLK_FREQ_MHZ;
	localparam int XFER_CYCLES = (T_XFER_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int DISCHARGE_CYCLES = (T_DISCHARGE_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
	localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
	localparam logic [CNT_W-1:0] BASE_STEP = 12'h001;
	localparam logic [HALT_W-1:0] HALT_RST = 8'h00;
	localparam logic [1:0] LAST_CH = 2'h2;

	typedef enum logic [0:0] {
		non_touch_state = 1'b0,
		touch_state = 1'b1
	} cht_mode_t;

	typedef enum logic [1:0] {
		seq_discharge = 2'b00,
		seq_transfer = 2'b01,
		seq_settle = 2'b10
	} cht_seq_t;

	typedef struct packed {
		cht_mode_t mode;
		logic seeded;
		logic held;
		logic [HALT_W-1:0] halt_cnt;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] baseline;
		logic touch_f;
		logic prox_f;
		logic hout;
	} cht_ch_t;

	typedef struct packed {
		cht_seq_t seq;
		logic [1:0] chan;
		logic [TIMER_W-1:0] timer;
		logic [TICK_W-1:0] tick;
		logic [CNT_W-1:0] conv_cnt;
		logic sample_valid;
		logic xfer_pulse;
		logic tx_drive;
		logic bool_oe;
		cht_ch_t [NUM_CH-1:0] ch;
	} cht_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} cht_sync_t;
endpackage : cht_pkg

//--- verilog/cht_sync.sv
/*
 * three-flop synchroniser for an asynchronous comparator level.
 * assumes the input may change at any time relative to clock.
 */
`timescale 1ns/100ps
module cht_sync (
	input wire logic clock,
	input wire logic clock_en,
	input wire logic sys_rst,
	input wire logic async_in,
	output logic level
);
	cht_pkg::cht_sync_t st_reg;
	cht_pkg::cht_sync_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// only an agreed pair counts, so one metastable sample cannot flip the level
		if (st_reg.s2 == st_reg.s3) begin
			st_next.level = st_reg.s3;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else if (clock_en) begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.level;
endmodule : cht_sync

//--- verilog/cht_top.sv
/*
 * conversion sequencer and per-channel hysteresis tracking for three sense channels.
 * assumes per-channel trip comparators from the analogue front end and static settings.
 */
`timescale 1ns/100ps
module cht_top #(
	parameter int CHANNEL_CYCLES = cht_pkg::CHANNEL_CYCLES_DFLT
) (
	input wire logic clock,
	input wire logic clock_en,
	input wire logic sys_rst,
	input wire logic [2:0] trip_in,
	input wire logic proj_mode,
	input wire logic [2:0] direct_mode,
	input wire logic act_on_touch,
	input wire logic [11:0] prox_threshold,
	input wire logic [11:0] touch_threshold,
	input wire logic [11:0] release_threshold,
	input wire logic [7:0] halt_samples,
	output logic conv_discharge,
	output logic [1:0] conv_channel,
	output logic transfer_pulse,
	output logic sample_valid,
	output logic sense_receive_mode,
	output logic transmit_electrode,
	output logic bool_out_o,
	output logic bool_out_oe,
	output logic [2:0][11:0] count_value,
	output logic [2:0][11:0] long_term_baseline,
	output logic [2:0] touch_flag,
	output logic [2:0] prox_flag,
	output logic [2:0] hysteresis_output,
	output logic [2:0] in_touch_state
);
	cht_pkg::cht_state_t st_reg;
	cht_pkg::cht_state_t st_next;
	logic [2:0] trip_lvl;
	logic [2:0] tdet;
	logic [2:0] pdet;
	logic [2:0] rdet;
	logic [2:0][11:0] base_trk;
	logic [2:0][11:0] base_recal;
	logic trip_now;
	logic [2:0] hyst_smp;

	genvar gi;
	generate
		for (gi = 0; gi < cht_pkg::NUM_CH; gi++) begin : g_ch
			cht_sync u_sync (
				.clock(clock),
				.clock_en(clock_en),
				.sys_rst(sys_rst),
				.async_in(trip_in[gi]),
				.level(trip_lvl[gi])
			);
			// 13-bit sums keep a large threshold from wrapping into a false hit
			assign tdet[gi] = ({1'b0, st_reg.conv_cnt} + {1'b0, touch_threshold})
				< {1'b0, st_reg.ch[gi].baseline};
			assign pdet[gi] = ({1'b0, st_reg.conv_cnt} + {1'b0, prox_threshold})
				< {1'b0, st_reg.ch[gi].baseline};
			assign rdet[gi] = {1'b0, st_reg.conv_cnt}
				> ({1'b0, st_reg.ch[gi].baseline} + {1'b0, release_threshold});
			// one step per sample: slow enough to follow drift, not a finger
			assign base_trk[gi] = (st_reg.conv_cnt > st_reg.ch[gi].baseline)
				? st_reg.ch[gi].baseline + cht_pkg::BASE_STEP
				: (st_reg.conv_cnt < st_reg.ch[gi].baseline)
				? st_reg.ch[gi].baseline - cht_pkg::BASE_STEP
				: st_reg.ch[gi].baseline;
			assign base_recal[gi] = (st_reg.ch[gi].baseline >= touch_threshold)
				? st_reg.ch[gi].baseline - touch_threshold : cht_pkg::CNT_RST;
			// settled sample on a tracking channel, shared by the checks
			assign hyst_smp[gi] = clock_en && st_reg.sample_valid && (st_reg.chan == 2'(gi))
				&& st_reg.ch[gi].seeded && !direct_mode[gi];
		end
	endgenerate

	assign trip_now = trip_lvl[st_reg.chan];

	always_comb begin
		st_next = st_reg;
		st_next.sample_valid = 1'b0;
		st_next.xfer_pulse = 1'b0;
		st_next.timer = st_reg.timer + 24'h000001;
		st_next.tx_drive = proj_mode & (st_reg.seq == cht_pkg::seq_transfer);
		st_next.bool_oe = ~proj_mode & (st_reg.ch[2].hout | st_reg.ch[1].hout | st_reg.ch[0].hout);
		unique case (st_reg.seq)
			cht_pkg::seq_discharge: begin
				st_next.tick = st_reg.tick + 8'h01;
				if (st_reg.tick >= 8'(cht_pkg::DISCHARGE_CYCLES - 1)) begin
					st_next.tick = 8'h00;
					st_next.conv_cnt = cht_pkg::CNT_RST;
					st_next.seq = cht_pkg::seq_transfer;
				end
			end
			cht_pkg::seq_transfer: begin
				st_next.tick = st_reg.tick + 8'h01;
				if (trip_now || st_reg.conv_cnt == cht_pkg::CNT_MAX) begin
					st_next.sample_valid = 1'b1;
					st_next.tick = 8'h00;
					st_next.seq = cht_pkg::seq_settle;
				end else if (st_reg.tick >= 8'(cht_pkg::XFER_CYCLES - 1)) begin
					st_next.tick = 8'h00;
					st_next.xfer_pulse = 1'b1;
					st_next.conv_cnt = st_reg.conv_cnt + 12'h001;
				end
			end
			cht_pkg::seq_settle: begin
				if (st_reg.timer >= 24'(CHANNEL_CYCLES - 1)) begin
					st_next.timer = 24'h000000;
					st_next.chan = (st_reg.chan == cht_pkg::LAST_CH) ? 2'h0 : st_reg.chan + 2'h1;
					st_next.seq = cht_pkg::seq_discharge;
				end
			end
			default: begin
				st_next.seq = cht_pkg::seq_discharge;
				st_next.timer = 24'h000000;
				st_next.tick = 8'h00;
			end
		endcase
		for (int i = 0; i < cht_pkg::NUM_CH; i++) begin
			if (st_reg.sample_valid && st_reg.chan == 2'(i)) begin
				st_next.ch[i].count = st_reg.conv_cnt;
				if (!st_reg.ch[i].seeded) begin
					st_next.ch[i].baseline = st_reg.conv_cnt;
					st_next.ch[i].seeded = 1'b1;
				end else if (direct_mode[i]) begin
					st_next.ch[i].touch_f = tdet[i];
					st_next.ch[i].prox_f = pdet[i];
					st_next.ch[i].hout = act_on_touch ? tdet[i] : pdet[i];
					st_next.ch[i].mode = cht_pkg::non_touch_state;
					st_next.ch[i].held = 1'b0;
					st_next.ch[i].halt_cnt = cht_pkg::HALT_RST;
					if (!pdet[i] && !tdet[i]) begin
						st_next.ch[i].baseline = base_trk[i];
					end
				end else begin
					unique case (st_reg.ch[i].mode)
						cht_pkg::non_touch_state: begin
							st_next.ch[i].touch_f = tdet[i];
							st_next.ch[i].prox_f = pdet[i];
							if ((st_reg.ch[i].held || act_on_touch) && tdet[i]) begin
								st_next.ch[i].baseline = base_recal[i];
								st_next.ch[i].mode = cht_pkg::touch_state;
								st_next.ch[i].hout = 1'b1;
								st_next.ch[i].held = 1'b0;
							end else if (st_reg.ch[i].held) begin
								if (!pdet[i]) begin
									st_next.ch[i].held = 1'b0;
									st_next.ch[i].hout = 1'b0;
								end else if (st_reg.ch[i].halt_cnt >= halt_samples) begin
									st_next.ch[i].held = 1'b0;
									st_next.ch[i].hout = 1'b0;
									st_next.ch[i].baseline = base_trk[i];
								end else begin
									// baseline left untouched here
									st_next.ch[i].halt_cnt = st_reg.ch[i].halt_cnt + 8'h01;
								end
							end else if (!act_on_touch && pdet[i]) begin
								st_next.ch[i].held = 1'b1;
								st_next.ch[i].hout = 1'b1;
								st_next.ch[i].halt_cnt = cht_pkg::HALT_RST;
							end else begin
								st_next.ch[i].baseline = base_trk[i];
							end
						end
						cht_pkg::touch_state: begin
							st_next.ch[i].touch_f = 1'b1;
							st_next.ch[i].prox_f = 1'b1;
							st_next.ch[i].baseline = base_trk[i];
							if (rdet[i]) begin
								st_next.ch[i].mode = cht_pkg::non_touch_state;
								st_next.ch[i].hout = 1'b0;
								st_next.ch[i].touch_f = 1'b0;
								st_next.ch[i].prox_f = 1'b0;
								st_next.ch[i].halt_cnt = cht_pkg::HALT_RST;
							end
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else if (clock_en) begin
			st_reg <= st_next;
		end
	end

	assign conv_discharge = (st_reg.seq == cht_pkg::seq_discharge);
	assign conv_channel = st_reg.chan;
	assign transfer_pulse = st_reg.xfer_pulse;
	assign sample_valid = st_reg.sample_valid;
	assign sense_receive_mode = proj_mode;
	assign transmit_electrode = st_reg.tx_drive & st_reg.xfer_pulse;
	// open drain: only ever pulls low
	assign bool_out_o = 1'b0;
	assign bool_out_oe = st_reg.bool_oe;

	generate
		for (gi = 0; gi < cht_pkg::NUM_CH; gi++) begin : g_out
			assign count_value[gi] = st_reg.ch[gi].count;
			assign long_term_baseline[gi] = st_reg.ch[gi].baseline;
			assign touch_flag[gi] = st_reg.ch[gi].touch_f;
			assign prox_flag[gi] = st_reg.ch[gi].prox_f;
			assign hysteresis_output[gi] = st_reg.ch[gi].hout;
			assign in_touch_state[gi] = (st_reg.ch[gi].mode == cht_pkg::touch_state);
		end
	endgenerate

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sample_pulse_a: assert property ((clock_en && st_reg.sample_valid) |=> !st_reg.sample_valid)
		else $error("sample strobe longer than one cycle");
	trip_end_a: assert property ((clock_en && st_reg.seq == cht_pkg::seq_transfer && trip_now)
		|=> (st_reg.sample_valid && st_reg.seq == cht_pkg::seq_settle))
		else $error("trip did not close the conversion");
	slot_rotate_a: assert property ((clock_en && st_reg.seq == cht_pkg::seq_settle
		&& st_next.seq == cht_pkg::seq_discharge) |=> (st_reg.chan != $past(st_reg.chan)))
		else $error("channel did not advance");
	bool_pin_a: assert property ((clock_en && proj_mode) |=> !bool_out_oe)
		else $error("boolean pin driven in projected mode");
	xfer_pulse_a: assert property ((clock_en && st_reg.xfer_pulse) |=> !st_reg.xfer_pulse)
		else $error("transfer strobe longer than one cycle");
	discharge_quiet_a: assert property ((clock_en && st_reg.seq == cht_pkg::seq_discharge)
		|=> (!st_reg.sample_valid && !st_reg.xfer_pulse))
		else $error("activity during discharge");
	conv_clear_a: assert property ((clock_en && st_reg.seq == cht_pkg::seq_discharge
		&& st_next.seq == cht_pkg::seq_transfer) |=> (st_reg.conv_cnt == cht_pkg::CNT_RST))
		else $error("transfer count not cleared");
	// a frozen cycle must not even advance the slot timer
	freeze_hold_a: assert property (!clock_en |=> $stable(st_reg))
		else $error("state moved while clock enable low");

	generate
		for (gi = 0; gi < cht_pkg::NUM_CH; gi++) begin : g_chk
			held_out_a: assert property (st_reg.ch[gi].held |-> (st_reg.ch[gi].hout
				&& st_reg.ch[gi].mode == cht_pkg::non_touch_state))
				else $error("held proximity without output");
			base_frozen_a: assert property ((st_reg.ch[gi].held && $past(st_reg.ch[gi].held))
				|-> $stable(st_reg.ch[gi].baseline))
				else $error("baseline moved while frozen");
			touch_recal_a: assert property ((st_reg.ch[gi].mode == cht_pkg::touch_state
				&& $past(st_reg.ch[gi].mode) == cht_pkg::non_touch_state
				&& $past(st_reg.ch[gi].baseline) >= $past(touch_threshold))
				|-> st_reg.ch[gi].baseline == $past(st_reg.ch[gi].baseline) - $past(touch_threshold))
				else $error("touch entry baseline wrong");
			release_out_a: assert property ((st_reg.ch[gi].mode == cht_pkg::non_touch_state
				&& $past(st_reg.ch[gi].mode) == cht_pkg::touch_state) |-> !st_reg.ch[gi].hout)
				else $error("output still active after release");
			halt_bound_a: assert property ((st_reg.ch[gi].held && $stable(halt_samples))
				|-> st_reg.ch[gi].halt_cnt <= halt_samples)
				else $error("held beyond halt timeout");
			direct_flag_a: assert property ((clock_en && st_reg.sample_valid && st_reg.chan == 2'(gi)
				&& direct_mode[gi] && st_reg.ch[gi].seeded)
				|=> (st_reg.ch[gi].touch_f == $past(tdet[gi])
				&& st_reg.ch[gi].mode == cht_pkg::non_touch_state))
				else $error("direct channel flag mismatch");
			count_load_a: assert property ((clock_en && st_reg.sample_valid && st_reg.chan == 2'(gi))
				|=> (st_reg.ch[gi].count == $past(st_reg.conv_cnt)))
				else $error("sample count not stored");
			prox_set_a: assert property ((hyst_smp[gi] && !st_reg.ch[gi].held && !act_on_touch
				&& st_reg.ch[gi].mode == cht_pkg::non_touch_state && pdet[gi])
				|=> (st_reg.ch[gi].held && st_reg.ch[gi].hout))
				else $error("proximity did not activate output");
			act_touch_a: assert property ((hyst_smp[gi] && act_on_touch && !st_reg.ch[gi].held
				&& st_reg.ch[gi].mode == cht_pkg::non_touch_state) |=> !st_reg.ch[gi].held)
				else $error("proximity held while touch selected");
			halt_drop_a: assert property ((hyst_smp[gi] && st_reg.ch[gi].held && pdet[gi] && !tdet[gi]
				&& st_reg.ch[gi].halt_cnt >= halt_samples)
				|=> (!st_reg.ch[gi].held && !st_reg.ch[gi].hout))
				else $error("halt timeout did not drop output");
			release_exit_a: assert property ((hyst_smp[gi] && rdet[gi]
				&& st_reg.ch[gi].mode == cht_pkg::touch_state)
				|=> (st_reg.ch[gi].mode == cht_pkg::non_touch_state && !st_reg.ch[gi].hout))
				else $error("release threshold did not end touch");
			touch_out_a: assert property ((st_reg.ch[gi].mode == cht_pkg::touch_state) |-> st_reg.ch[gi].hout)
				else $error("touch state without output");
			track_up_a: assert property ((hyst_smp[gi] && st_reg.ch[gi].mode == cht_pkg::touch_state
				&& st_reg.conv_cnt > st_reg.ch[gi].baseline)
				|=> (st_reg.ch[gi].baseline == $past(st_reg.ch[gi].baseline) + 12'h001))
				else $error("baseline did not follow upward drift");
			track_down_a: assert property ((hyst_smp[gi] && st_reg.ch[gi].mode == cht_pkg::touch_state
				&& st_reg.conv_cnt < st_reg.ch[gi].baseline)
				|=> (st_reg.ch[gi].baseline == $past(st_reg.ch[gi].baseline) - 12'h001))
				else $error("baseline did not follow downward drift");
		end
	endgenerate
endmodule : cht_top

//--- test/cht_afe_model.sv
/*
 * analogue front end model: one trip comparator per sense channel.
 * assumes the tracker sequencer outputs and a per-channel target count set by the bench.
 */
`timescale 1ns/100ps
module cht_afe_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic conv_discharge,
	input wire logic [1:0] conv_channel,
	input wire logic transfer_pulse,
	input wire logic [2:0][11:0] target,
	output logic [2:0] trip_in
);
	logic [11:0] xfer_cnt_reg;
	logic toggle_reg;

	// charge builds per transfer, emptied by discharge
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			xfer_cnt_reg <= 12'h000;
			toggle_reg <= 1'b0;
		end else begin
			toggle_reg <= !toggle_reg;
			if (conv_discharge)
				xfer_cnt_reg <= 12'h000;
			else if (transfer_pulse)
				xfer_cnt_reg <= xfer_cnt_reg + 12'h001;
		end
	end

	// unselected comparators toggle so a stale level is never trusted
	always_comb begin
		trip_in = {3{toggle_reg}};
		trip_in[conv_channel] = !conv_discharge && (xfer_cnt_reg >= target[conv_channel]);
	end
endmodule : cht_afe_model

//--- test/testbench.sv
/*
 * self-checking bench for the hysteresis tracker with front end model.
 * assumes a short slot parameter; settings static between samples.
 */
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic proj_mode = 1'b0;
	logic clock_en = 1'b1;
	int xfer_seen = 0;
	logic act_on_touch = 1'b0;
	logic [2:0] direct_mode = 3'b100;
	logic [2:0][11:0] target = {3{12'h01E}};
	logic [2:0] trip_in;
	logic conv_discharge, transfer_pulse, sample_valid, sense_receive_mode;
	logic transmit_electrode, bool_out_o, bool_out_oe;
	logic [1:0] conv_channel;
	logic [2:0][11:0] count_value, long_term_baseline;
	logic [2:0] touch_flag, prox_flag, hysteresis_output, in_touch_state;
	logic [1:0] prev_ch = 2'h0;
	logic seen = 1'b0;
	int fails = 0;
	int total_checks = 0;

	cht_top #(.CHANNEL_CYCLES(2000)) cht_top_inst (.clock(clock), .clock_en(clock_en), .sys_rst(sys_rst),
		.trip_in(trip_in), .proj_mode(proj_mode), .direct_mode(direct_mode), .act_on_touch(act_on_touch),
		.prox_threshold(12'h005), .touch_threshold(12'h00A), .release_threshold(12'h003),
		.halt_samples(8'h01), .conv_discharge(conv_discharge), .conv_channel(conv_channel),
		.transfer_pulse(transfer_pulse), .sample_valid(sample_valid), .sense_receive_mode(sense_receive_mode),
		.transmit_electrode(transmit_electrode), .bool_out_o(bool_out_o), .bool_out_oe(bool_out_oe),
		.count_value(count_value), .long_term_baseline(long_term_baseline), .touch_flag(touch_flag),
		.prox_flag(prox_flag), .hysteresis_output(hysteresis_output), .in_touch_state(in_touch_state));

	cht_afe_model cht_afe_model_inst (.clock(clock), .sys_rst(sys_rst), .conv_discharge(conv_discharge),
		.conv_channel(conv_channel), .transfer_pulse(transfer_pulse), .target(target), .trip_in(trip_in));

	initial begin
		forever #12.5 clock = !clock;
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task check_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task check_cnt(input string what, input logic [11:0] exp, input logic [11:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check_cnt

	// returns at the negedge after that channel's outputs were updated
	task sample(input logic [1:0] ch);
		int n;
		n = 0;
		@(negedge clock);
		while (!(sample_valid === 1'b1 && conv_channel === ch) && n < 7000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 7000) begin
			fails++;
			$display("ERROR sample_valid expected 1 seen timeout");
		end
		@(negedge clock);
	endtask : sample

	always @(negedge clock) begin
		if (sample_valid === 1'b1) begin
			if (seen)
				check_cnt("conv_channel", {10'h000, (prev_ch == 2'h2) ? 2'h0 : prev_ch + 2'h1}, {10'h000, conv_channel});
			prev_ch = conv_channel;
			seen = 1'b1;
		end
	end

	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		end_of_test;
	end

	initial begin
		#5;
		check_bit("conv_discharge", 1'b1, conv_discharge);
		check_bit("hysteresis_output", 1'b0, hysteresis_output[0]);
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		sample(2'h0);
		check_cnt("count_value", 12'h01E, count_value[0]);
		check_cnt("long_term_baseline", 12'h01E, long_term_baseline[0]);
		sample(2'h1);
		sample(2'h2);
		@(posedge clock);
		target <= {3{12'h016}};
		$display("test seeding done");
		sample(2'h0);
		check_bit("hysteresis_output", 1'b1, hysteresis_output[0]);
		check_cnt("long_term_baseline", 12'h01E, long_term_baseline[0]);
		sample(2'h1);
		check_bit("hysteresis_output", 1'b1, hysteresis_output[1]);
		sample(2'h2);
		check_bit("prox_flag", 1'b1, prox_flag[2]);
		check_bit("touch_flag", 1'b0, touch_flag[2]);
		check_bit("hysteresis_output", 1'b1, hysteresis_output[2]);
		check_cnt("long_term_baseline", 12'h01E, long_term_baseline[2]);
		check_bit("bool_out_oe", 1'b1, bool_out_oe);
		check_bit("bool_out_o", 1'b0, bool_out_o);
		@(posedge clock);
		target <= {12'h01E, 12'h00F, 12'h016};
		sample(2'h0);
		check_bit("hysteresis_output", 1'b1, hysteresis_output[0]);
		check_cnt("long_term_baseline", 12'h01E, long_term_baseline[0]);
		sample(2'h1);
		check_bit("in_touch_state", 1'b1, in_touch_state[1]);
		check_cnt("long_term_baseline", 12'h014, long_term_baseline[1]);
		check_bit("hysteresis_output", 1'b1, hysteresis_output[1]);
		sample(2'h2);
		check_bit("prox_flag", 1'b0, prox_flag[2]);
		check_bit("hysteresis_output", 1'b0, hysteresis_output[2]);
		$display("test activation done");
		sample(2'h0);
		check_bit("hysteresis_output", 1'b0, hysteresis_output[0]);
		check_cnt("long_term_baseline", 12'h01D, long_term_baseline[0]);
		sample(2'h1);
		check_cnt("long_term_baseline", 12'h013, long_term_baseline[1]);
		check_bit("in_touch_state", 1'b1, in_touch_state[1]);
		@(posedge clock);
		target[1] <= 12'h01E;
		sample(2'h2);
		sample(2'h0);
		sample(2'h1);
		check_bit("in_touch_state", 1'b0, in_touch_state[1]);
		check_bit("hysteresis_output", 1'b0, hysteresis_output[1]);
		$display("test release done");
		@(posedge clock);
		act_on_touch <= 1'b1;
		target[2] <= 12'h016;
		sample(2'h2);
		check_bit("prox_flag", 1'b1, prox_flag[2]);
		check_bit("hysteresis_output", 1'b0, hysteresis_output[2]);
		@(posedge clock);
		proj_mode <= 1'b1;
		sample(2'h0);
		while (transfer_pulse !== 1'b1)
			@(negedge clock);
		check_bit("transmit_electrode", 1'b1, transmit_electrode);
		check_bit("sense_receive_mode", 1'b1, sense_receive_mode);
		check_bit("bool_out_oe", 1'b0, bool_out_oe);
		$display("test modes done");
		// freeze mid conversion: no transfer may happen, count must survive
		@(posedge clock);
		clock_en <= 1'b0;
		xfer_seen = 0;
		repeat (200) begin
			@(negedge clock);
			if (transfer_pulse === 1'b1)
				xfer_seen++;
		end
		check_cnt("transfer_pulse", 12'h000, 12'(xfer_seen));
		@(posedge clock);
		clock_en <= 1'b1;
		sample(2'h1);
		check_cnt("count_value", 12'h01E, count_value[1]);
		$display("test freeze done");
		end_of_test;
	end
endmodule : testbench
